// *** rtl/wdr_watchdog.sv ***
// Purpose: watchdog timer with timed change sequence and reset-cause flags
// Assumes: all inputs synchronous to clk_sys; wdt_tick is one pulse per oscillator cycle
// Notes:   reset_n acts as the power-on reset of this block
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - scan flag, bit 4, set by scan-chain reset; cleared by power-on or zero write
// - watchdog flag, bit 3, set on watchdog reset; cleared by power-on or zero write
// - brown-out flag, bit 2, set on brown-out; cleared by power-on or zero write
// - pin flag, bit 1, set on external reset; cleared by power-on or zero write
// - power-on flag, bit 0, set at power-on; cleared only by software zero write
// - control bits 7 to 5 read as zero
// - clearing enable is ignored unless change-enable is currently one
// - change-enable clears itself four system clock cycles after being written
// - time-out select is written only while change-enable is one; a chip reset clears it
// - writing one enables the watchdog; a permitted zero disables it
// - with the always-on fuse the watchdog stays enabled regardless of sequence
// - enabled watchdog counts oscillator cycles; codes 0 to 3 give 16K to 128K
// - codes 4 to 7 give 256K, 512K, 1024K and 2048K oscillator cycles
// - time-out issues a one-cycle reset pulse
// - counter restarts on restart command, while disabled, and on any chip reset
// - with the always-on fuse the enable bit always reads as one
module wdr_watchdog #(
  parameter int BASE_CYCLES = wdr_pkg::BASE_TIMEOUT_CYCLES
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire wdr_pkg::wdr_ahb_req_t ahb_req,
  output var  wdr_pkg::wdr_ahb_rsp_t ahb_rsp,
  input  wire wdr_pkg::wdr_cause_t   reset_cause,
  input  wire logic                  always_on_fuse,
  input  wire logic                  wdt_tick,
  output logic                       wdt_reset_pulse
);
  import wdr_pkg::*;

  initial begin
    if (BASE_CYCLES < 2 || (longint'(BASE_CYCLES) << 7) > (longint'(1) << CNT_W)) begin
      $error("BASE_CYCLES does not fit the counter");
    end
  end

  typedef struct packed {
    logic [FLAG_W-1:0]     status;
    logic                  enable;
    logic [CTRL_SEL_W-1:0] sel;
    logic [2:0]            ce_cnt;
    logic [CNT_W-1:0]      count;
    logic                  dph_valid;
    logic                  dph_write;
    logic [7:0]            dph_addr;
    logic [31:0]           hrdata;
    logic                  hreadyout;
    logic                  wdt_reset;
  } wdr_state_t;

  wdr_state_t s_r;
  wdr_state_t s_nxt;

  // last count before time-out for a select code
  function automatic logic [CNT_W-1:0] last_count(input logic [CTRL_SEL_W-1:0] sel);
    longint lim;
    lim = longint'(BASE_CYCLES) << sel;
    return CNT_W'(lim - 1);
  endfunction : last_count

  function automatic logic [31:0] read_value(input logic [7:0] addr,
                                             input wdr_state_t st,
                                             input logic fuse);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (addr == ADDR_STATUS) begin
      v[FLAG_W-1:0] = st.status;
    end else if (addr == ADDR_CONTROL) begin
      v[CTRL_CE]                               = (st.ce_cnt != 3'h0);
      v[CTRL_EN]                               = st.enable | fuse;
      v[CTRL_SEL_LSB +: CTRL_SEL_W]            = st.sel;
    end
    return v;
  endfunction : read_value

  logic       wr_status;
  logic       wr_control;
  logic       wr_restart;
  logic       ce_open;
  logic       en_now;
  logic       timeout;
  logic       chip_rst;
  logic       reopen;
  logic       sel_chg;
  logic [7:0] wbyte;

  always_comb begin
    wbyte      = ahb_req.hwdata[7:0];
    wr_status  = s_r.dph_valid && s_r.dph_write && s_r.dph_addr == ADDR_STATUS;
    wr_control = s_r.dph_valid && s_r.dph_write && s_r.dph_addr == ADDR_CONTROL;
    wr_restart = s_r.dph_valid && s_r.dph_write && s_r.dph_addr == ADDR_RESTART;
    ce_open    = (s_r.ce_cnt != 3'h0);
    reopen     = wr_control && wbyte[CTRL_CE] && wbyte[CTRL_EN];
    // a new select restarts the count, so a count past a shorter limit cannot run to wrap
    sel_chg    = wr_control && ce_open && !wbyte[CTRL_CE] && !reopen &&
                 wbyte[CTRL_SEL_LSB +: CTRL_SEL_W] != s_r.sel;
    en_now     = s_r.enable | always_on_fuse;
    timeout    = en_now && wdt_tick && !wr_restart && !sel_chg &&
                 s_r.count == last_count(s_r.sel);
    chip_rst   = timeout | reset_cause.scan | reset_cause.brownout | reset_cause.pin;

    s_nxt           = s_r;
    s_nxt.hreadyout = 1'b1;
    s_nxt.wdt_reset = timeout;

    // window counts down every cycle
    if (ce_open) begin
      s_nxt.ce_cnt = s_r.ce_cnt - 3'h1;
    end

    if (wr_control) begin
      if (reopen) begin
        s_nxt.enable = 1'b1;
        s_nxt.ce_cnt = CE_WINDOW_CYCLES;
      end else if (ce_open && !wbyte[CTRL_CE]) begin
        s_nxt.enable = wbyte[CTRL_EN];
        s_nxt.sel    = wbyte[CTRL_SEL_LSB +: CTRL_SEL_W];
        s_nxt.ce_cnt = 3'h0;
      end else if (wbyte[CTRL_EN]) begin
        s_nxt.enable = 1'b1;
      end
    end

    // counting against the selected time-out
    if (!en_now || wr_restart || sel_chg) begin
      s_nxt.count = '0;
    end else if (wdt_tick) begin
      if (timeout) begin
        s_nxt.count = '0;
      end else begin
        s_nxt.count = s_r.count + CNT_W'(1);
      end
    end

    // a chip reset returns the control to its initial state
    if (chip_rst) begin
      s_nxt.enable = 1'b0;
      s_nxt.sel    = '0;
      s_nxt.ce_cnt = 3'h0;
      s_nxt.count  = '0;
    end

    // set wins over a software clear in the same cycle
    if (wr_status) begin
      s_nxt.status = s_r.status & wbyte[FLAG_W-1:0];
    end
    if (reset_cause.scan) begin
      s_nxt.status[FLAG_SCAN] = 1'b1;
    end
    if (timeout) begin
      s_nxt.status[FLAG_WDOG] = 1'b1;
    end
    if (reset_cause.brownout) begin
      s_nxt.status[FLAG_BROWN] = 1'b1;
    end
    if (reset_cause.pin) begin
      s_nxt.status[FLAG_PIN] = 1'b1;
    end

    // address phase; read data taken from the post-write state so
    // a read right after a write sees the new value
    if (ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1]) begin
      s_nxt.dph_valid = 1'b1;
      s_nxt.dph_write = ahb_req.hwrite;
      s_nxt.dph_addr  = ahb_req.haddr[7:0];
      if (!ahb_req.hwrite) begin
        s_nxt.hrdata = read_value(ahb_req.haddr[7:0], s_nxt, always_on_fuse);
      end
    end else if (ahb_req.hready) begin
      s_nxt.dph_valid = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_r           <= '0;
      s_r.status    <= STATUS_RST;
      s_r.hreadyout <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    ahb_rsp.hrdata    = s_r.hrdata;
    ahb_rsp.hreadyout = s_r.hreadyout;
    ahb_rsp.hresp     = HRESP_OKAY;
    wdt_reset_pulse   = s_r.wdt_reset;
  end

  // checks
  logic [31:0] ctrl_view;
  assign ctrl_view = read_value(ADDR_CONTROL, s_r, always_on_fuse);

  property p_scan_set;
    @(posedge clk_sys) disable iff (!reset_n)
      reset_cause.scan |=> s_r.status[FLAG_SCAN];
  endproperty
  a_scan_set: assert property (p_scan_set) else $error("scan flag not set");

  property p_wdog_flag;
    @(posedge clk_sys) disable iff (!reset_n)
      $rose(wdt_reset_pulse) |-> s_r.status[FLAG_WDOG] && !s_r.enable && s_r.count == '0;
  endproperty
  a_wdog_flag: assert property (p_wdog_flag) else $error("time-out without flag or reset");

  property p_brown_set;
    @(posedge clk_sys) disable iff (!reset_n)
      reset_cause.brownout |=> s_r.status[FLAG_BROWN] && s_r.count == '0;
  endproperty
  a_brown_set: assert property (p_brown_set) else $error("brown-out flag not set");

  property p_pin_set;
    @(posedge clk_sys) disable iff (!reset_n)
      reset_cause.pin |=> s_r.status[FLAG_PIN] && !s_r.enable;
  endproperty
  a_pin_set: assert property (p_pin_set) else $error("pin flag not set");

  property p_por_hold;
    @(posedge clk_sys) disable iff (!reset_n)
      $fell(s_r.status[FLAG_POR]) |-> $past(wr_status) && !$past(wbyte[FLAG_POR]);
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("power-on flag lost");

  property p_reserved;
    @(posedge clk_sys) disable iff (!reset_n)
      ctrl_view[7:5] == 3'h0 && ahb_rsp.hrdata[31:5] == 27'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_en_guard;
    @(posedge clk_sys) disable iff (!reset_n)
      $fell(s_r.enable) |-> $past(ce_open) || $past(chip_rst);
  endproperty
  a_en_guard: assert property (p_en_guard) else $error("enable cleared outside window");

  property p_ce_close;
    @(posedge clk_sys) disable iff (!reset_n)
      (s_r.ce_cnt == CE_WINDOW_CYCLES && !reopen) ##1 (!reopen)[*3] |=> !ce_open;
  endproperty
  a_ce_close: assert property (p_ce_close) else $error("change window not closed");

  property p_sel_guard;
    @(posedge clk_sys) disable iff (!reset_n)
      $changed(s_r.sel) |-> $past(ce_open) || $past(chip_rst);
  endproperty
  a_sel_guard: assert property (p_sel_guard) else $error("select changed outside window");

  property p_enable_write;
    @(posedge clk_sys) disable iff (!reset_n)
      wr_control && wbyte[CTRL_EN] && !chip_rst |=> s_r.enable;
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  property p_fuse_on;
    @(posedge clk_sys) disable iff (!reset_n)
      always_on_fuse |-> ctrl_view[CTRL_EN] && en_now;
  endproperty
  a_fuse_on: assert property (p_fuse_on) else $error("fuse does not hold enable");

  property p_timeout;
    @(posedge clk_sys) disable iff (!reset_n)
      en_now && wdt_tick && !wr_restart && !sel_chg && s_r.count == last_count(s_r.sel)
      |=> wdt_reset_pulse ##1 !wdt_reset_pulse;
  endproperty
  a_timeout: assert property (p_timeout) else $error("time-out pulse wrong");

  property p_limit;
    @(posedge clk_sys) disable iff (!reset_n)
      s_r.count <= last_count(s_r.sel) || $changed(s_r.sel);
  endproperty
  a_limit: assert property (p_limit) else $error("counter passed time-out");

  property p_restart;
    @(posedge clk_sys) disable iff (!reset_n)
      wr_restart || !en_now |=> s_r.count == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("counter not restarted");

  property p_reopen;
    @(posedge clk_sys) disable iff (!reset_n)
      reopen && !chip_rst |=> s_r.ce_cnt == CE_WINDOW_CYCLES && s_r.enable;
  endproperty
  a_reopen: assert property (p_reopen) else $error("window not reopened");

endmodule : wdr_watchdog

`default_nettype wire

// *** rtl/wdr_pkg.sv ***
// Purpose: constants and carrier types for the watchdog and reset-cause block
// Assumes: AHB-Lite slave with 32-bit data, one word per register
// Notes:   low address byte decodes the register; upper address bits are ignored
package wdr_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_RESTART = 8'h08;

  // reset_cause_status fields
  localparam int FLAG_POR   = 0;
  localparam int FLAG_PIN   = 1;
  localparam int FLAG_BROWN = 2;
  localparam int FLAG_WDOG  = 3;
  localparam int FLAG_SCAN  = 4;
  localparam int FLAG_W     = 5;
  localparam logic [4:0] STATUS_RST = 5'h01;

  // watchdog_control fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_SEL_W   = 3;
  localparam int CTRL_EN      = 3;
  localparam int CTRL_CE      = 4;
  localparam int CTRL_W       = 5;

  // change-enable window length in system clock cycles
  localparam logic [2:0] CE_WINDOW_CYCLES = 3'h4;
  // shortest time-out, in watchdog oscillator cycles
  localparam int BASE_TIMEOUT_CYCLES = 16384;
  localparam int CNT_W               = 21;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } wdr_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } wdr_ahb_rsp_t;

  // reset sources other than power-on and the watchdog itself
  typedef struct packed {
    logic scan;
    logic brownout;
    logic pin;
  } wdr_cause_t;

endpackage : wdr_pkg

// *** verif/wdr_watchdog_tb_top.sv ***
// Purpose: self-checking bench for the watchdog and reset-cause block
// Assumes: zero-wait AHB-Lite slave; small BASE_CYCLES keeps time-outs short
// Notes:   after time zero every input changes by non-blocking assignment just after a rising edge
`timescale 1ns/100ps
`default_nettype none
module wdr_watchdog_tb_top;
  import wdr_pkg::*;
  localparam int BASE = 4;
  logic         clk_sys;
  logic         reset_n;
  logic         fuse;
  logic         tk;
  logic         we;
  logic         pulse;
  logic [1:0]   ht;
  logic [31:0]  ha;
  logic [31:0]  hw;
  logic [31:0]  q;
  wdr_cause_t   cause;
  wdr_ahb_req_t req;
  wdr_ahb_rsp_t rsp;
  int           err_count;
  int           compares;
  int           n;

  // hsel and hsize are fixed: one slave, word transfers only
  assign req = '{hsel: 1'b1, haddr: ha, htrans: ht, hwrite: we, hsize: 3'h2,
                 hwdata: hw, hready: rsp.hreadyout};

  wdr_watchdog #(.BASE_CYCLES(BASE)) DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .ahb_req(req), .ahb_rsp(rsp),
    .reset_cause(cause), .always_on_fuse(fuse), .wdt_tick(tk), .wdt_reset_pulse(pulse));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // no fixed latency assumed: wait for hready under a bound
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (rsp.hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_count++;
      test_done();
    end
  endtask : wait_rdy

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    ht <= HTRANS_NONSEQ;
    ha <= {24'h00_0000, a};
    we <= w;
    wait_rdy();
    ht <= 2'h0;
    hw <= {24'h00_0000, d};
    wait_rdy();
    q = rsp.hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(q, {24'h00_0000, exp});
    chk({31'h0, rsp.hresp}, {31'h0, HRESP_OKAY});
  endtask : rd

  // one tick per two clocks; the pulse is looked at right after each tick edge
  task automatic run_to(input int exp);
    n = 0;
    do begin
      @(posedge clk_sys);
      tk <= 1'b1;
      @(posedge clk_sys);
      tk <= 1'b0;
      #1;
      n++;
    end while (pulse !== 1'b1 && n < 600);
    chk(32'(n), 32'(exp));
    @(posedge clk_sys);
    #1;
    chk({31'h0, pulse}, 32'h0000_0000);
  endtask : run_to

  initial begin
    #2_000_000;
    err_count++;
    test_done();
  end

  initial begin
    reset_n = 1'b0;
    {fuse, tk, we, ht, ha, hw, cause} = '0;
    err_count = 0;
    compares = 0;
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rd(ADDR_STATUS, 8'h01);
    rd(ADDR_CONTROL, 8'h00);
    rd(8'h0C, 8'h00);
    wr(ADDR_STATUS, 8'h1E);
    rd(ADDR_STATUS, 8'h00);
    for (int i = 0; i < 3; i++) begin
      cause <= wdr_cause_t'(3'b001 << i);
      @(posedge clk_sys);
      cause <= '0;
      rd(ADDR_STATUS, {3'h0, i == 2, 1'b0, i == 1, i == 0, 1'b0});
      wr(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS, 8'h00);
    end
    wr(ADDR_CONTROL, 8'hEB);
    rd(ADDR_CONTROL, 8'h08);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, 8'h08);
    wr(ADDR_CONTROL, 8'h18);
    repeat (4) @(posedge clk_sys);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, 8'h08);
    wr(ADDR_CONTROL, 8'h18);
    rd(ADDR_CONTROL, 8'h18);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(ADDR_CONTROL, 8'h18);
      wr(ADDR_CONTROL, 8'h08 | 8'(s));
      rd(ADDR_CONTROL, 8'h08 | 8'(s));
      run_to(BASE << s);
      rd(ADDR_STATUS, 8'h08);
      rd(ADDR_CONTROL, 8'h00);
      wr(ADDR_STATUS, 8'h00);
    end
    wr(ADDR_CONTROL, 8'h08);
    repeat (3) begin
      @(posedge clk_sys);
      tk <= 1'b1;
      @(posedge clk_sys);
      tk <= 1'b0;
    end
    wr(ADDR_RESTART, 8'h01);
    run_to(BASE);
    fuse <= 1'b1;
    @(posedge clk_sys);
    rd(ADDR_CONTROL, 8'h08);
    wr(ADDR_CONTROL, 8'h18);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CONTROL, 8'h08);
    run_to(BASE);
    test_done();
  end
endmodule : wdr_watchdog_tb_top
`default_nettype wire
